// file: rtl/switch_port_config_pkg.sv
package switch_port_config_pkg;

    typedef logic [23:0] port_vec_t;
    typedef logic [3:0] vlan_set_t;
    typedef logic [4:0] port_id_t;

    typedef enum logic [1:0] {
        SRAM_64K,
        SRAM_128K,
        SRAM_256K,
        SRAM_512K
    } sram_size_e;

endpackage : switch_port_config_pkg

// file: rtl/switch_port_config_regs.sv
`timescale 1ns/1ps
`include "switch_port_config_regs.svh"
module switch_port_config_regs #(
    parameter int NUM_PORTS = 24,
    parameter int NUM_VLANS = 4
) (
    input wire logic CLK_SYS_I,
    input wire logic SRST_I,
    // management command port (after serial framing)
    input wire logic CMD_VALID_I,
    input wire logic CMD_WRITE_I,
    input wire logic [1:0] CMD_DEV_ID_I,
    input wire logic [7:0] CMD_REG_I,
    input wire logic [4:0] CMD_INDEX_I,
    input wire logic [23:0] CMD_WDATA_I,
    output logic RSP_VALID_O,
    output logic [23:0] RSP_RDATA_O,
    // automatic PHY management results
    input wire logic PHY_UPD_VALID_I,
    input wire logic [4:0] PHY_UPD_PORT_I,
    input wire logic PHY_SPEED_I,
    input wire logic PHY_LINK_I,
    input wire logic PHY_DUPLEX_I,
    input wire logic PHY_PAUSE_I,
    // strap levels and system control
    input wire logic [23:0] STRAP_CFG_I,
    input wire logic SYS_READY_I,
    input wire logic PHY_MGMT_DONE_I,
    input wire logic SYS_ERROR_I,
    // per-port and per-VLAN controls
    output logic [23:0] PORT_SPEED_100_O,
    output logic [23:0] PORT_LINK_UP_O,
    output logic [23:0] PORT_FULL_DUPLEX_O,
    output logic [23:0] PORT_PAUSE_TX_EN_O,
    output logic [23:0] PORT_BLOCK_LISTEN_O,
    output logic [23:0] PORT_BP_EN_O,
    output logic [23:0] PORT_ENABLE_O,
    output logic [95:0] VLAN_MEMBER_O,
    output logic [19:0] VLAN_DUMP_PORT_O,
    // decoded system configuration
    output logic [2:0] SRAM_RD_DLY_UNITS_O,
    output logic SRAM_RD_INVERT_O,
    output logic [2:0] SRAM_CK_DLY_UNITS_O,
    output logic SRAM_CK_INVERT_O,
    output logic [1:0] SRAM_SIZE_O,
    output logic MDC_FALLING_O,
    output logic [10:0] LONG_FRAME_LIMIT_O,
    output logic UNKNOWN_FLOOD_O,
    output logic EXCESS_COLL_DROP_O,
    output logic BCAST_FC_EN_O,
    output logic SW_RESET_REQ_O,
    output logic HW_RESET_REQ_O,
    output logic SYSTEM_START_O,
    output logic RMII_TX_RISING_O,
    output logic RMII_RX_FALLING_O
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // merge a software write and a single-port hardware update into a
    // status vector; a software write replaces all 24 bits, so it wins over a same-cycle hardware update
    function automatic switch_port_config_pkg::port_vec_t merge_status(
        input switch_port_config_pkg::port_vec_t cur,
        input logic sw_we,
        input switch_port_config_pkg::port_vec_t sw_data,
        input logic hw_we,
        input logic [4:0] hw_port,
        input logic hw_bit
    );
        switch_port_config_pkg::port_vec_t res;
        res = cur;
        if (hw_we)
            res[hw_port] = hw_bit;
        if (sw_we)
            res = sw_data;
        return res;
    endfunction : merge_status

    // read delay: units sit in the upper three bits, even codes invert
    function automatic logic [3:0] rd_delay(input logic [3:0] code);
        return {code[3:1], ~code[0]};
    endfunction : rd_delay

    // clock delay: 010,011,000,001,110,111,100,101 count 0 to 7
    function automatic logic [3:0] ck_delay(input logic [3:0] code);
        return {code[3], ~code[2], code[1], ~code[0]};
    endfunction : ck_delay

    ////////////////////////////////////////////////////////////////////////
    // state

    logic [23:0] speed_ff, link_ff, duplex_ff, pause_ff;
    logic [23:0] forward_block_bits_ff;
    logic [23:0] backpressure_disable_bits_ff;
    logic [23:0] port_isolate_bits_ff;
    logic [23:0] management_inhibit_bits_ff;
    logic [23:0] system_configuration_word_ff;
    logic [3:0] vlan_membership_entry_ff [NUM_PORTS];
    logic [4:0] vlan_dump_port_entry_ff [NUM_VLANS];
    logic rsp_valid_ff;
    logic [23:0] rsp_rdata_ff;
    logic err_seen_ff;

    ////////////////////////////////////////////////////////////////////////
    // command decode

    wire id_match = CMD_DEV_ID_I ==
        system_configuration_word_ff[`CFG_DEV_ID_MSB:`CFG_DEV_ID_LSB];
    wire cmd_take = CMD_VALID_I && id_match;
    wire wr_take = cmd_take && CMD_WRITE_I;
    wire rd_take = cmd_take && !CMD_WRITE_I;

    wire we_speed = wr_take && (CMD_REG_I == `REG_SPEED);
    wire we_link = wr_take && (CMD_REG_I == `REG_LINK);
    wire we_fwd = wr_take && (CMD_REG_I == `REG_FWD_BLOCK);
    wire we_bp = wr_take && (CMD_REG_I == `REG_BP_DISABLE);
    wire we_iso = wr_take && (CMD_REG_I == `REG_ISOLATE);
    wire we_vlan = wr_take && (CMD_REG_I == `REG_VLAN_MEMBER) &&
        (CMD_INDEX_I <= `MAX_PORT_ID);
    // out-of-range port IDs are ignored so the dump entry stays valid
    wire we_dump = wr_take && (CMD_REG_I == `REG_DUMP_PORT) &&
        (CMD_INDEX_I < 5'(NUM_VLANS)) &&
        (CMD_WDATA_I[4:0] <= `MAX_PORT_ID);
    wire we_cfg = wr_take && (CMD_REG_I == `REG_SYS_CONFIG);
    wire we_pause = wr_take && (CMD_REG_I == `REG_PAUSE);
    wire we_duplex_bits = wr_take && (CMD_REG_I == `REG_DUPLEX);
    wire we_inh = wr_take && (CMD_REG_I == `REG_MGMT_INHIBIT);

    ////////////////////////////////////////////////////////////////////////
    // automatic PHY management gating

    wire hw_upd_ok = PHY_UPD_VALID_I &&
        (PHY_UPD_PORT_I <= `MAX_PORT_ID) &&
        !system_configuration_word_ff[`CFG_PM_DIS] &&
        !management_inhibit_bits_ff[PHY_UPD_PORT_I];

    wire [23:0] nxt_speed = merge_status(speed_ff, we_speed, CMD_WDATA_I,
        hw_upd_ok, PHY_UPD_PORT_I, PHY_SPEED_I);
    wire [23:0] nxt_link = merge_status(link_ff, we_link, CMD_WDATA_I,
        hw_upd_ok, PHY_UPD_PORT_I, PHY_LINK_I);
    wire [23:0] nxt_duplex = merge_status(duplex_ff, we_duplex_bits, CMD_WDATA_I,
        hw_upd_ok, PHY_UPD_PORT_I, PHY_DUPLEX_I);
    wire [23:0] nxt_pause = merge_status(pause_ff, we_pause, CMD_WDATA_I,
        hw_upd_ok, PHY_UPD_PORT_I, PHY_PAUSE_I);

    ////////////////////////////////////////////////////////////////////////
    // read mux; unmapped registers read as zero

    logic [23:0] nxt_rdata;
    always_comb
    begin
        nxt_rdata = 24'h000000;
        case (CMD_REG_I)
            `REG_SPEED: nxt_rdata = speed_ff;
            `REG_LINK: nxt_rdata = link_ff;
            `REG_FWD_BLOCK: nxt_rdata = forward_block_bits_ff;
            `REG_BP_DISABLE: nxt_rdata = backpressure_disable_bits_ff;
            `REG_ISOLATE: nxt_rdata = port_isolate_bits_ff;
            `REG_VLAN_MEMBER:
                if (CMD_INDEX_I <= `MAX_PORT_ID)
                    nxt_rdata = {20'h00000,
                        vlan_membership_entry_ff[CMD_INDEX_I]};
            `REG_DUMP_PORT:
                if (CMD_INDEX_I < 5'(NUM_VLANS))
                    nxt_rdata = {19'h00000,
                        vlan_dump_port_entry_ff[CMD_INDEX_I[1:0]]};
            `REG_SYS_CONFIG: nxt_rdata = system_configuration_word_ff;
            `REG_PAUSE: nxt_rdata = pause_ff;
            `REG_DUPLEX: nxt_rdata = duplex_ff;
            `REG_MGMT_INHIBIT: nxt_rdata = management_inhibit_bits_ff;
            default: nxt_rdata = 24'h000000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge CLK_SYS_I)
    begin
        if (SRST_I)
        begin
            speed_ff <= `RST_PORT_VEC;
            link_ff <= `RST_PORT_VEC;
            duplex_ff <= `RST_PORT_VEC;
            pause_ff <= `RST_PORT_VEC;
            forward_block_bits_ff <= `RST_PORT_VEC;
            backpressure_disable_bits_ff <= `RST_PORT_VEC;
            port_isolate_bits_ff <= `RST_PORT_VEC;
            management_inhibit_bits_ff <= `RST_PORT_VEC;
        end
        else
        begin
            speed_ff <= nxt_speed;
            link_ff <= nxt_link;
            duplex_ff <= nxt_duplex;
            pause_ff <= nxt_pause;
            if (we_fwd) forward_block_bits_ff <= CMD_WDATA_I;
            if (we_bp) backpressure_disable_bits_ff <= CMD_WDATA_I;
            if (we_iso) port_isolate_bits_ff <= CMD_WDATA_I;
            if (we_inh) management_inhibit_bits_ff <= CMD_WDATA_I;
        end
    end

    // straps are sampled on every clock while reset is held, so the last
    // sample before release is what the word starts from
    always_ff @(posedge CLK_SYS_I)
    begin
        if (SRST_I)
        begin
            system_configuration_word_ff <= STRAP_CFG_I;
        end
        else if (we_cfg)
        begin
            system_configuration_word_ff <= CMD_WDATA_I;
        end
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            if (SRST_I)
                vlan_membership_entry_ff[p] <= (p == 0) ?
                    `RST_VLAN_PORT0 : `RST_VLAN_OTHER;
            else if (we_vlan && (CMD_INDEX_I == 5'(p)))
                vlan_membership_entry_ff[p] <= CMD_WDATA_I[3:0];
        end
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        for (int v = 0; v < NUM_VLANS; v++)
        begin
            if (SRST_I)
                vlan_dump_port_entry_ff[v] <= `RST_DUMP_PORT;
            else if (we_dump && (CMD_INDEX_I == 5'(v)))
                vlan_dump_port_entry_ff[v] <= CMD_WDATA_I[4:0];
        end
    end

    // one answer per accepted command, a cycle after it is taken
    always_ff @(posedge CLK_SYS_I)
    begin
        if (SRST_I)
        begin
            rsp_valid_ff <= 1'b0;
            rsp_rdata_ff <= 24'h000000;
        end
        else
        begin
            rsp_valid_ff <= cmd_take;
            rsp_rdata_ff <= rd_take ? nxt_rdata : 24'h000000;
        end
    end

    // system error edge turns into a single reset request pulse
    always_ff @(posedge CLK_SYS_I)
    begin
        if (SRST_I)
            err_seen_ff <= 1'b0;
        else
            err_seen_ff <= SYS_ERROR_I;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    wire [23:0] cfg = system_configuration_word_ff;
    wire err_rise = SYS_ERROR_I && !err_seen_ff;
    wire [3:0] rd_dec = rd_delay(cfg[`CFG_RD_DLY_MSB:`CFG_RD_DLY_LSB]);
    wire [3:0] ck_dec = ck_delay(cfg[`CFG_CK_DLY_MSB:`CFG_CK_DLY_LSB]);

    assign RSP_VALID_O = rsp_valid_ff;
    assign RSP_RDATA_O = rsp_rdata_ff;
    assign PORT_SPEED_100_O = speed_ff;
    assign PORT_LINK_UP_O = link_ff;
    assign PORT_FULL_DUPLEX_O = duplex_ff;
    assign PORT_PAUSE_TX_EN_O = pause_ff;
    // the MAC keeps forwarding BPDUs from a blocked port
    assign PORT_BLOCK_LISTEN_O = forward_block_bits_ff;
    assign PORT_BP_EN_O = ~backpressure_disable_bits_ff;
    assign PORT_ENABLE_O = ~port_isolate_bits_ff;

    genvar g;
    generate
        for (g = 0; g < NUM_PORTS; g++)
        begin : g_vlan
            assign VLAN_MEMBER_O[4*g +: 4] = vlan_membership_entry_ff[g];
        end
        for (g = 0; g < NUM_VLANS; g++)
        begin : g_dump
            assign VLAN_DUMP_PORT_O[5*g +: 5] = vlan_dump_port_entry_ff[g];
        end
    endgenerate

    assign SRAM_RD_DLY_UNITS_O = rd_dec[3:1];
    assign SRAM_RD_INVERT_O = rd_dec[0];
    assign SRAM_CK_DLY_UNITS_O = ck_dec[3:1];
    assign SRAM_CK_INVERT_O = ck_dec[0];
    assign SRAM_SIZE_O = cfg[`CFG_SRAM_MSB:`CFG_SRAM_LSB];
    assign MDC_FALLING_O = cfg[`CFG_MDC_FALL];
    assign LONG_FRAME_LIMIT_O = cfg[`CFG_LONG_SEL] ?
        `LONG_FRAME_LONG : `LONG_FRAME_SHORT;
    // flooding does not relieve software of programming dump ports
    assign UNKNOWN_FLOOD_O = cfg[`CFG_UNK_FLOOD];
    assign EXCESS_COLL_DROP_O = cfg[`CFG_EXC_DROP];
    assign BCAST_FC_EN_O = !cfg[`CFG_BC_FC_DIS];
    assign SW_RESET_REQ_O = err_rise && !cfg[`CFG_ERR_HW];
    assign HW_RESET_REQ_O = err_rise && cfg[`CFG_ERR_HW];
    assign SYSTEM_START_O = !SRST_I && (!cfg[`CFG_CPU_START] ||
        (SYS_READY_I && PHY_MGMT_DONE_I));
    assign RMII_TX_RISING_O = cfg[`CFG_TX_RISE];
    assign RMII_RX_FALLING_O = cfg[`CFG_RX_FALL];

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (SRST_I);

    sequence hw_upd_s;
        hw_upd_ok && !we_speed;
    endsequence

    hw_speed_update_a: assert property (
        hw_upd_s |=> PORT_SPEED_100_O[$past(PHY_UPD_PORT_I)] ==
            $past(PHY_SPEED_I))
        else $error("allowed phy update did not reach speed bit");

    inhibit_hold_a: assert property (
        (PHY_UPD_VALID_I && (PHY_UPD_PORT_I <= 5'h17) && !we_link &&
         (cfg[16] || management_inhibit_bits_ff[PHY_UPD_PORT_I]))
        |=> $stable(PORT_LINK_UP_O))
        else $error("inhibited port status changed by hardware");

    status_reset_a: assert property (
        $fell(SRST_I) |-> (PORT_SPEED_100_O == 24'h000000) &&
            (PORT_FULL_DUPLEX_O == 24'h000000))
        else $error("status bits not zero after reset");

    block_write_a: assert property (
        we_fwd |=> PORT_BLOCK_LISTEN_O == $past(CMD_WDATA_I))
        else $error("forward block write not applied");

    bp_enable_a: assert property (
        we_bp |=> PORT_BP_EN_O == ~$past(CMD_WDATA_I))
        else $error("back-pressure enable not inverse of written bits");

    vlan_reset_a: assert property (
        $fell(SRST_I) |-> (VLAN_MEMBER_O[3:0] == 4'hf) &&
            (VLAN_MEMBER_O[7:4] == 4'h1))
        else $error("vlan membership reset wrong");

    dump_range_a: assert property (
        (wr_take && (CMD_REG_I == 8'h18) && (CMD_WDATA_I[4:0] > 5'h17))
        |=> $stable(VLAN_DUMP_PORT_O))
        else $error("invalid dump port accepted");

    strap_capture_a: assert property (
        $fell(SRST_I) |-> cfg == $past(STRAP_CFG_I))
        else $error("strap value not captured at reset release");

    id_filter_a: assert property (
        (CMD_VALID_I && !id_match) |=> !RSP_VALID_O)
        else $error("answered command with foreign device id");

    start_wait_a: assert property (
        (cfg[19] && !(SYS_READY_I && PHY_MGMT_DONE_I)) |-> !SYSTEM_START_O)
        else $error("system started before software released it");

    rd_delay_a: assert property (
        SRAM_RD_INVERT_O == !cfg[0] && SRAM_RD_DLY_UNITS_O == cfg[3:1])
        else $error("sram read delay decode wrong");
endmodule : switch_port_config_regs

// file: rtl/switch_port_config_regs.svh
`ifndef SWITCH_PORT_CONFIG_REGS_SVH
`define SWITCH_PORT_CONFIG_REGS_SVH

// register numbers as seen on the management command port
`define REG_SPEED 8'h12
`define REG_LINK 8'h13
`define REG_FWD_BLOCK 8'h14
`define REG_BP_DISABLE 8'h15
`define REG_ISOLATE 8'h16
`define REG_VLAN_MEMBER 8'h17
`define REG_DUMP_PORT 8'h18
`define REG_SYS_CONFIG 8'h19
`define REG_PAUSE 8'h1a
`define REG_DUPLEX 8'h1b
`define REG_MGMT_INHIBIT 8'h1d

// reset values and highest port ID
`define RST_PORT_VEC 24'h000000
`define RST_VLAN_PORT0 4'hf
`define RST_VLAN_OTHER 4'h1
`define RST_DUMP_PORT 5'h00
`define MAX_PORT_ID 5'h17

// system configuration word fields
`define CFG_RD_DLY_MSB 3
`define CFG_RD_DLY_LSB 0
`define CFG_CK_DLY_MSB 7
`define CFG_CK_DLY_LSB 4
`define CFG_SRAM_MSB 9
`define CFG_SRAM_LSB 8
`define CFG_MDC_FALL 10
`define CFG_LONG_SEL 11
`define CFG_UNK_FLOOD 12
`define CFG_EXC_DROP 15
`define CFG_PM_DIS 16
`define CFG_BC_FC_DIS 17
`define CFG_ERR_HW 18
`define CFG_CPU_START 19
`define CFG_DEV_ID_MSB 21
`define CFG_DEV_ID_LSB 20
`define CFG_TX_RISE 22
`define CFG_RX_FALL 23

// long frame thresholds in bytes
`define LONG_FRAME_SHORT 11'd1518
`define LONG_FRAME_LONG 11'd1530

`endif

// file: verif/mgmt_cpu_model.sv
`timescale 1ns/1ps
module mgmt_cpu_model (
    input wire logic clk_i,
    output logic valid_o,
    output logic write_o,
    output logic [1:0] id_o,
    output logic [7:0] reg_o,
    output logic [4:0] index_o,
    output logic [23:0] wdata_o,
    input wire logic rsp_valid_i,
    input wire logic [23:0] rsp_rdata_i
);
    initial
    begin
        valid_o = 1'b0;
        write_o = 1'b0;
        id_o = 2'h0;
        reg_o = 8'h00;
        index_o = 5'h00;
        wdata_o = 24'h000000;
    end

    ////////////////////////////////////////////////////////////////////////
    // one command per call; the answer stands only in the cycle after
    // the taking edge, so it is sampled just after that edge
    task automatic access(input logic wr, input logic [1:0] id,
        input logic [7:0] rg, input logic [4:0] ix, input logic [23:0] wd,
        output logic ok, output logic [23:0] rd);
        @(posedge clk_i);
        valid_o <= 1'b1;
        write_o <= wr;
        id_o <= id;
        reg_o <= rg;
        index_o <= ix;
        wdata_o <= wd;
        @(posedge clk_i);
        valid_o <= 1'b0;
        // released index and data lines are scrambled so stale values never help
        index_o <= ~ix;
        wdata_o <= ~wd;
        #1;
        ok = rsp_valid_i;
        rd = rsp_rdata_i;
    endtask : access
endmodule : mgmt_cpu_model

// file: verif/switch_port_config_regs_tb.sv
`timescale 1ns/1ps
`include "switch_port_config_regs.svh"
module switch_port_config_regs_tb;
    logic clk, srst, phy_v, ready, done, err, c_v, c_w, r_v;
    // one distinct bit per status so a speed or duplex input swapped with link or pause shows up
    logic [3:0] phy_b;
    logic [4:0] phy_port, c_ix;
    logic [1:0] c_id, dev_id, sz;
    logic [7:0] c_reg;
    logic [23:0] strap, c_wd, r_rd, spd, lnk, dpx, pse, blk, bp, en;
    logic [95:0] vm;
    logic [19:0] dp;
    logic [2:0] rdu, cku, u;
    logic [10:0] lim;
    logic rdi, cki, mdc, fld, exd, bfc, swr, hwr, st, txr, rxf, ok;
    logic [23:0] r;
    int n_fail = 0;
    int n_compared = 0;
    localparam logic [7:0] vec_regs [8] = '{`REG_SPEED, `REG_LINK,
        `REG_FWD_BLOCK, `REG_BP_DISABLE, `REG_ISOLATE, `REG_PAUSE,
        `REG_DUPLEX, `REG_MGMT_INHIBIT};
    localparam logic [3:0] ck_tab [8] = '{4'h5, 4'h7, 4'h1, 4'h3, 4'hd,
        4'hf, 4'h9, 4'hb};

    switch_port_config_regs dut_u (.CLK_SYS_I(clk), .SRST_I(srst),
        .CMD_VALID_I(c_v), .CMD_WRITE_I(c_w), .CMD_DEV_ID_I(c_id),
        .CMD_REG_I(c_reg), .CMD_INDEX_I(c_ix), .CMD_WDATA_I(c_wd),
        .RSP_VALID_O(r_v), .RSP_RDATA_O(r_rd), .PHY_UPD_VALID_I(phy_v),
        .PHY_UPD_PORT_I(phy_port), .PHY_SPEED_I(phy_b[0]),
        .PHY_LINK_I(phy_b[1]), .PHY_DUPLEX_I(phy_b[2]),
        .PHY_PAUSE_I(phy_b[3]), .STRAP_CFG_I(strap),
        .SYS_READY_I(ready), .PHY_MGMT_DONE_I(done), .SYS_ERROR_I(err),
        .PORT_SPEED_100_O(spd), .PORT_LINK_UP_O(lnk),
        .PORT_FULL_DUPLEX_O(dpx), .PORT_PAUSE_TX_EN_O(pse),
        .PORT_BLOCK_LISTEN_O(blk), .PORT_BP_EN_O(bp), .PORT_ENABLE_O(en),
        .VLAN_MEMBER_O(vm), .VLAN_DUMP_PORT_O(dp),
        .SRAM_RD_DLY_UNITS_O(rdu), .SRAM_RD_INVERT_O(rdi),
        .SRAM_CK_DLY_UNITS_O(cku), .SRAM_CK_INVERT_O(cki),
        .SRAM_SIZE_O(sz), .MDC_FALLING_O(mdc), .LONG_FRAME_LIMIT_O(lim),
        .UNKNOWN_FLOOD_O(fld), .EXCESS_COLL_DROP_O(exd),
        .BCAST_FC_EN_O(bfc), .SW_RESET_REQ_O(swr), .HW_RESET_REQ_O(hwr),
        .SYSTEM_START_O(st), .RMII_TX_RISING_O(txr),
        .RMII_RX_FALLING_O(rxf));

    mgmt_cpu_model mgmt_u (.clk_i(clk), .valid_o(c_v), .write_o(c_w),
        .id_o(c_id), .reg_o(c_reg), .index_o(c_ix), .wdata_o(c_wd),
        .rsp_valid_i(r_v), .rsp_rdata_i(r_rd));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [95:0] seen, input logic [95:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] rg, input logic [4:0] ix,
        input logic [23:0] d);
        mgmt_u.access(1'b1, dev_id, rg, ix, d, ok, r);
        check(ok, 1'b1);
    endtask : wr

    task automatic rd(input logic [7:0] rg, input logic [4:0] ix,
        input logic [23:0] e);
        mgmt_u.access(1'b0, dev_id, rg, ix, 24'h000000, ok, r);
        check({ok, r}, {1'b1, e});
    endtask : rd

    task automatic phy(input logic [4:0] p, input logic [3:0] v);
        @(posedge clk);
        phy_v <= 1'b1;
        phy_port <= p;
        phy_b <= v;
        @(posedge clk);
        phy_v <= 1'b0;
        #1;
    endtask : phy

    function automatic logic [23:0] pat(input int i);
        return 24'h96a5c3 + 24'(i);
    endfunction : pat

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // whole run is well under a thousand commands of two cycles each
    initial
    begin
        #100000;
        n_fail++;
        summarize();
    end

    initial
    begin
        {srst, phy_v, phy_b, ready, done, err} = 9'b100000000;
        phy_port = 5'h00;
        dev_id = 2'h0;
        strap = 24'hc00900;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        strap <= 24'h000000;
        for (int i = 0; i < 8; i++)
            rd(vec_regs[i], 5'h00, 24'h000000);
        check({bp, en}, {48{1'b1}});
        rd(`REG_VLAN_MEMBER, 5'h00, 24'h00000f);
        rd(`REG_VLAN_MEMBER, 5'h17, 24'h000001);
        rd(`REG_DUMP_PORT, 5'h03, 24'h000000);
        rd(`REG_SYS_CONFIG, 5'h00, 24'hc00900);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
            wr(vec_regs[i], 5'h00, pat(i));
        for (int i = 0; i < 8; i++)
            rd(vec_regs[i], 5'h00, pat(i));
        check({spd, lnk, blk}, {pat(0), pat(1), pat(2)});
        check({pse, dpx}, {pat(5), pat(6)});
        check({bp, en}, {~pat(3), ~pat(4)});
        for (int i = 0; i < 8; i++)
            wr(vec_regs[i], 5'h00, 24'h000000);
        $display("test port vectors done");
        phy(5'h03, 4'h5);
        phy(5'h17, 4'ha);
        check({spd, lnk, dpx, pse},
            {24'h000008, 24'h800000, 24'h000008, 24'h800000});
        wr(`REG_MGMT_INHIBIT, 5'h00, 24'h000010);
        phy(5'h04, 4'hf);
        check(spd, 24'h000008);
        wr(`REG_SYS_CONFIG, 5'h00, 24'hc10900);
        phy(5'h05, 4'hf);
        check({lnk, dpx, pse}, {24'h800000, 24'h000008, 24'h800000});
        wr(`REG_SPEED, 5'h00, 24'h000020);
        check(spd, 24'h000020);
        $display("test phy update done");
        for (int c = 0; c < 16; c++)
        begin
            for (int k = 0; k < 8; k++)
                if (ck_tab[k] == (4'(c) | 4'h1))
                    u = 3'(k);
            wr(`REG_SYS_CONFIG, 5'h00, 24'hc00900 | {16'h0, 4'(c), 4'(c)});
            check({rdu, rdi, cku, cki},
                {3'(c >> 1), ~c[0], u, ~c[0]});
        end
        check({sz, mdc, lim, fld, exd, bfc, txr, rxf},
            {2'b01, 1'b0, 11'd1530, 5'b00111});
        wr(`REG_SYS_CONFIG, 5'h00, 24'h2e9600);
        dev_id = 2'h2;
        rd(`REG_SYS_CONFIG, 5'h00, 24'h2e9600);
        check({sz, mdc, lim, fld, exd, bfc, txr, rxf},
            {2'b10, 1'b1, 11'd1518, 5'b11000});
        mgmt_u.access(1'b1, 2'h0, `REG_SPEED, 5'h00, 24'hffffff, ok, r);
        check({ok, spd}, {1'b0, 24'h000020});
        $display("test config done");
        check(st, 1'b0);
        @(posedge clk);
        ready <= 1'b1;
        #1 check(st, 1'b0);
        @(posedge clk);
        done <= 1'b1;
        #1 check(st, 1'b1);
        @(posedge clk);
        err <= 1'b1;
        #1 check({swr, hwr}, 2'b01);
        @(posedge clk);
        {ready, done, err} <= 3'b000;
        #1 check({swr, hwr}, 2'b00);
        wr(`REG_SYS_CONFIG, 5'h00, 24'h2a9600);
        @(posedge clk);
        err <= 1'b1;
        #1 check({swr, hwr, st}, 3'b100);
        wr(`REG_SYS_CONFIG, 5'h00, 24'h229600);
        check(st, 1'b1);
        $display("test system control done");
        wr(`REG_VLAN_MEMBER, 5'h17, 24'h000006);
        wr(`REG_VLAN_MEMBER, 5'h18, 24'h00000f);
        rd(`REG_VLAN_MEMBER, 5'h17, 24'h000006);
        check(vm, {4'h6, {22{4'h1}}, 4'hf});
        for (int v = 0; v < 4; v++)
            wr(`REG_DUMP_PORT, 5'(v), 24'(23 - v));
        wr(`REG_DUMP_PORT, 5'h03, 24'h000018);
        wr(`REG_DUMP_PORT, 5'h04, 24'h000005);
        rd(`REG_DUMP_PORT, 5'h03, 24'h000014);
        check(dp, {5'd20, 5'd21, 5'd22, 5'd23});
        wr(8'h1c, 5'h00, 24'h123456);
        rd(8'h1c, 5'h00, 24'h000000);
        $display("test vlan done");
        summarize();
    end
endmodule : switch_port_config_regs_tb
